// File: hdl/spc_host.sv
/*
 * Download host for a byte-wide slave configuration port: pulses the
 * restart pin, waits for the device to come ready, clocks bytes in,
 * honours busy and keeps clocking until completion or error.
 * Assumes status pins are asynchronous and a byte source on ref_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"

module spc_host #(
    parameter int PROG_LOW_CYC = `SPC_PROG_LOW_CYC,  // restart low, ref cycles
    parameter int HALF_CYC     = `SPC_CFG_HALF_CYC,  // cfg clock half period
    parameter int FLUSH_CLKS   = `SPC_FLUSH_CLKS     // start-up clocks allowed
) (
    input  wire logic                 ref_clk_in,       // 100 MHz reference
    input  wire logic                 arst_n_in,        // async reset, active low
    input  wire logic                 start_in,         // begin a download
    input  wire logic                 pullup_disable_in,// wanted pull-up control
    input  wire logic [7:0]           data_in,          // next byte
    input  wire logic                 data_valid_in,    // byte offered
    input  wire logic                 data_last_in,     // byte ends the file
    output logic                      data_ready_out,   // byte taken
    input  wire spc_pkg::spc_stat_type stat_in,         // device status pins
    output spc_pkg::spc_pins_type     pins_out,         // pins to device
    output logic                      cfg_clk_out,      // configuration clock
    output logic                      busy_out,         // download running
    output logic                      done_ok_out,      // configured
    output logic                      error_out         // init low or timeout
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    spc_pkg::spc_state_type state_r, state_nxt;
    logic [15:0]            cnt_r, cnt_nxt;
    logic                   seen_low_r, seen_low_nxt;
    logic                   hold_r, hold_nxt;
    logic                   last_r, last_nxt;
    logic [7:0]             byte_r, byte_nxt;
    logic                   pud_r, pud_nxt;
    spc_pkg::spc_stat_type  meta_r, sync_r;
    logic                   run;
    logic                   rise;
    logic                   fall;
    logic                   take;

    // ------------------------------------------------------------------
    // status synchronisers
    // ------------------------------------------------------------------
    // pins from the device are asynchronous; only sync_r is ever read
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= '{init_n: 1'b0, done: 1'b0, busy: 1'b1};
            sync_r <= '{init_n: 1'b0, done: 1'b0, busy: 1'b1};
        end else begin
            meta_r <= stat_in;
            sync_r <= meta_r;
        end
    end

    // ------------------------------------------------------------------
    // configuration clock
    // ------------------------------------------------------------------
    // clock runs only with a byte held, or while flushing start-up
    assign run = ((state_r == spc_pkg::SPC_LOAD) && hold_r) ||
                 (state_r == spc_pkg::SPC_FLUSH);

    spc_clk_div #(
        .HALF_CYC    (HALF_CYC)
    ) u_div (
        .ref_clk_in  (ref_clk_in),
        .arst_n_in   (arst_n_in),
        .run_in      (run),
        .cfg_clk_out (cfg_clk_out),
        .rise_out    (rise),
        .fall_out    (fall)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // busy is seen two to three ref cycles late; with the default
    // 12.5 MHz clock that still lands before the sampling edge
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        seen_low_nxt = seen_low_r;
        hold_nxt     = hold_r;
        last_nxt     = last_r;
        byte_nxt     = byte_r;
        pud_nxt      = pud_r;
        take         = 1'b0;
        case (state_r)
            spc_pkg::SPC_IDLE, spc_pkg::SPC_DONE, spc_pkg::SPC_ERR: begin
                if (start_in) begin
                    state_nxt    = spc_pkg::SPC_PROG;
                    cnt_nxt      = 16'h0000;
                    pud_nxt      = pullup_disable_in;
                    hold_nxt     = 1'b0;
                    last_nxt     = 1'b0;
                end
            end
            spc_pkg::SPC_PROG: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(PROG_LOW_CYC - 1)) begin
                    state_nxt    = spc_pkg::SPC_WAIT;
                    seen_low_nxt = 1'b0;
                end
            end
            spc_pkg::SPC_WAIT: begin
                // a stale high from before the restart must not count
                if (!sync_r.init_n) begin
                    seen_low_nxt = 1'b1;
                end else if (seen_low_r) begin
                    state_nxt = spc_pkg::SPC_LOAD;
                end
            end
            spc_pkg::SPC_LOAD: begin
                take = !hold_r && data_valid_in;
                if (take) begin
                    hold_nxt = 1'b1;
                    byte_nxt = data_in;
                    last_nxt = data_last_in;
                end
                if (rise && hold_r && !sync_r.busy) begin
                    hold_nxt = 1'b0;
                    if (last_r) begin
                        state_nxt = spc_pkg::SPC_FLUSH;
                        cnt_nxt   = 16'h0000;
                    end
                end
                if (sync_r.done) begin
                    state_nxt = spc_pkg::SPC_DONE;
                end else if (!sync_r.init_n) begin
                    state_nxt = spc_pkg::SPC_ERR;
                end
            end
            spc_pkg::SPC_FLUSH: begin
                if (rise) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
                if (sync_r.done) begin
                    state_nxt = spc_pkg::SPC_DONE;
                end else if (!sync_r.init_n) begin
                    state_nxt = spc_pkg::SPC_ERR;
                end else if (fall && cnt_r >= 16'(FLUSH_CLKS)) begin
                    state_nxt = spc_pkg::SPC_ERR;
                end
            end
            default: begin
                state_nxt = spc_pkg::SPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r    <= spc_pkg::SPC_IDLE;
            cnt_r      <= 16'h0000;
            seen_low_r <= 1'b0;
            hold_r     <= 1'b0;
            last_r     <= 1'b0;
            byte_r     <= `SPC_DATA_RST;
            pud_r      <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            seen_low_r <= seen_low_nxt;
            hold_r     <= hold_nxt;
            last_r     <= last_nxt;
            byte_r     <= byte_nxt;
            pud_r      <= pud_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pins and status
    // ------------------------------------------------------------------
    // select and write stay low from ready through start-up clocks
    always_comb begin
        pins_out.program_restart_n  = (state_r != spc_pkg::SPC_PROG);
        pins_out.chip_sel_n         = !((state_r == spc_pkg::SPC_LOAD) ||
                                        (state_r == spc_pkg::SPC_FLUSH));
        pins_out.read_write_n       = pins_out.chip_sel_n;
        pins_out.mode               = `SPC_MODE_SLAVE_PAR;
        pins_out.pullup_disable_ctl = pud_r;
        pins_out.data               = byte_r;
    end

    assign data_ready_out = take;
    assign busy_out       = (state_r == spc_pkg::SPC_PROG) ||
                            (state_r == spc_pkg::SPC_WAIT) ||
                            (state_r == spc_pkg::SPC_LOAD) ||
                            (state_r == spc_pkg::SPC_FLUSH);
    assign done_ok_out    = (state_r == spc_pkg::SPC_DONE);
    assign error_out      = (state_r == spc_pkg::SPC_ERR);

endmodule : spc_host

`default_nettype wire

// File: hdl/spc_defs.svh
/*
 * Timing counts, pin values and reset values for the slave parallel
 * configuration host. Assumes a 100 MHz reference clock.
 */
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define SPC_REF_CLK_NS      10
`define SPC_PROG_LOW_NS     500
// least time, so round up to whole reference cycles
`define SPC_PROG_LOW_CYC    ((`SPC_PROG_LOW_NS + `SPC_REF_CLK_NS - 1) / `SPC_REF_CLK_NS)
`define SPC_CFG_HALF_CYC    4
`define SPC_FLUSH_CLKS      64

// ------------------------------------------------------------------
// pin values
// ------------------------------------------------------------------
`define SPC_MODE_SLAVE_PAR  3'h6
`define SPC_MODE_RST        3'h6
`define SPC_DATA_RST        8'h00

`endif

// File: hdl/spc_pkg.sv
/*
 * Types shared by the configuration host modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spc_pkg;

    // pins that the host drives toward the device
    typedef struct packed {
        logic       program_restart_n;  // restart, active low
        logic       chip_sel_n;         // chip select, active low
        logic       read_write_n;       // low selects write
        logic [2:0] mode;               // mode select, m2..m0
        logic       pullup_disable_ctl; // 0: pull-ups during config
        logic [7:0] data;               // configuration byte
    } spc_pins_type;

    // status pins that the device drives back
    typedef struct packed {
        logic init_n;                   // initialization indicator
        logic done;                     // completion indicator
        logic busy;                     // not ready for data
    } spc_stat_type;

    // gray along idle, program, wait, load, flush, done
    typedef enum logic [2:0] {
        SPC_IDLE  = 3'h0,
        SPC_PROG  = 3'h1,
        SPC_WAIT  = 3'h3,
        SPC_LOAD  = 3'h2,
        SPC_FLUSH = 3'h6,
        SPC_DONE  = 3'h7,
        SPC_ERR   = 3'h5
    } spc_state_type;

endpackage : spc_pkg

// File: hdl/spc_clk_div.sv
/*
 * Configuration clock divider: makes cfg_clk from the reference clock
 * and flags the reference cycle in which each edge is produced.
 * Lets the caller lower run_in with the clock high; that high phase still completes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.svh"

module spc_clk_div #(
    parameter int HALF_CYC = `SPC_CFG_HALF_CYC   // ref cycles per half period
) (
    input  wire logic ref_clk_in,   // 100 MHz reference
    input  wire logic arst_n_in,    // async reset, active low
    input  wire logic run_in,       // keep toggling
    output logic      cfg_clk_out,  // divided clock, from flop
    output logic      rise_out,     // cfg_clk rises at next edge
    output logic      fall_out      // cfg_clk falls at next edge
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       clk_r;
    logic       clk_nxt;
    logic       step;
    logic       wrap;

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    // a high phase always completes, so the clock never stops high
    always_comb begin
        step     = clk_r | run_in;
        wrap     = step && (cnt_r == 8'(HALF_CYC - 1));
        cnt_nxt  = cnt_r;
        clk_nxt  = clk_r;
        if (wrap) begin
            cnt_nxt = 8'h00;
            clk_nxt = ~clk_r;
        end else if (step) begin
            cnt_nxt = cnt_r + 8'h01;
        end
        rise_out = wrap & ~clk_r;
        fall_out = wrap & clk_r;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r <= 8'h00;
            clk_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign cfg_clk_out = clk_r;

endmodule : spc_clk_div

`default_nettype wire

// File: bench/spc_host_chk.sv
/* pin-level checker for the configuration host.
   assumes it is bound onto spc_host running with HALF_CYC of 4. */
`timescale 1ns/1ps
`default_nettype none
module spc_host_chk #(
    parameter int PROG_LOW_CYC = 50                   // restart low, ref cycles
) (
    input wire logic                  ref_clk_in,     // reference clock
    input wire logic                  arst_n_in,      // async reset, active low
    input wire spc_pkg::spc_stat_type stat_in,        // device status pins
    input wire spc_pkg::spc_pins_type pins_out,       // pins to device
    input wire logic                  cfg_clk_out,    // configuration clock
    input wire logic                  busy_out,       // download running
    input wire logic                  done_ok_out,    // configured
    input wire logic                  error_out       // failed
);
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;
    // counts the cycles the restart pin spends low
    always_comb low_cnt_nxt = pins_out.program_restart_n ? 8'h00 : low_cnt_r + 8'h01;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end
    default clocking cb_ref @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    // a busy device must see the same byte for a whole further period
    sequence s_busy_edge;
        $rose(cfg_clk_out) && stat_in.busy;
    endsequence
    sequence s_byte_kept;
        ##1 $stable(pins_out.data) [*7];
    endsequence
    a_prog_low_len: assert property ($rose(pins_out.program_restart_n) |->
        low_cnt_r == PROG_LOW_CYC) else $error("restart low time wrong");
    a_mode_pattern: assert property (pins_out.mode == 3'h6)
        else $error("mode pins wrong");
    a_sel_paired: assert property (pins_out.chip_sel_n == pins_out.read_write_n)
        else $error("write control not with select");
    a_sel_held: assert property (busy_out && !$past(pins_out.chip_sel_n) |->
        !pins_out.chip_sel_n) else $error("select dropped mid download");
    a_pullup_steady: assert property (busy_out && $past(busy_out) |->
        $stable(pins_out.pullup_disable_ctl)) else $error("pull-up control moved");
    a_data_setup: assert property ($rose(cfg_clk_out) |->
        pins_out.data == $past(pins_out.data, 3)) else $error("byte not set up");
    a_busy_keeps: assert property (s_busy_edge |-> s_byte_kept)
        else $error("byte not held while busy");
    a_init_first: assert property ($fell(pins_out.chip_sel_n) |->
        pins_out.program_restart_n && stat_in.init_n) else $error("select before ready");
    a_done_cause: assert property ($rose(done_ok_out) |->
        $past(stat_in.done, 2) || $past(stat_in.done, 3)) else $error("done without device");
    a_end_quiet: assert property (done_ok_out || error_out |->
        pins_out.chip_sel_n ##1 !cfg_clk_out) else $error("end state still driving");
    c_busy_seen: cover property (s_busy_edge);
endmodule : spc_host_chk
`default_nettype wire

// File: bench/spc_dev_model.sv
/* behavioural slave configuration device with busy stalls and crc failure.
   assumes board pull-ups on init and done, so a released pin reads 1. */
`timescale 1ns/1ps
`default_nettype none
module spc_dev_model #(
    parameter int FILE_LEN     = 12,                  // bytes in the file
    parameter int STARTUP_CLKS = 4                    // clocks after the file
) (
    input  wire spc_pkg::spc_pins_type pins_in,       // host pins
    input  wire logic                  cfg_clk_in,    // host configuration clock
    input  wire logic                  crc_err_in,    // fail the next byte
    input  wire logic                  hang_in,       // never finish start-up
    output spc_pkg::spc_stat_type      stat_out,      // status pins
    output logic [15:0]                rx_sum_out,    // folded bytes taken
    output logic [7:0]                 rx_cnt_out     // bytes taken
);
    logic    init_n = 1'b1;
    logic    done = 1'b0;
    logic    busy = 1'b0;
    int      left = 0;
    int      tail = 0;
    realtime t_fall = 0;
    wire     pullups_on = !pins_in.pullup_disable_ctl && !done;
    wire     chip_sel_out_n = !done;
    assign stat_out = '{init_n: init_n, done: done, busy: busy};
    initial rx_cnt_out = 8'h00;
    initial rx_sum_out = 16'h0000;
    // restart: memory clears while init is held low
    always @(negedge pins_in.program_restart_n) begin
        t_fall = $realtime;
        init_n = 1'b0;
        done = 1'b0;
    end
    always @(posedge pins_in.program_restart_n) begin
        if ($realtime - t_fall >= 500.0 && !init_n) begin
            rx_cnt_out = 8'h00;
            rx_sum_out = 16'h0000;
            tail = 0;
            #300;
            init_n = (pins_in.mode == 3'h6);
        end
    end
    // capture only while selected, writing and still configuring;
    // once done the pins are user i/o and clocks are ignored
    always @(posedge cfg_clk_in) begin
        if (init_n && !done &&
            !pins_in.chip_sel_n && !pins_in.read_write_n) begin
            if (rx_cnt_out == FILE_LEN) begin
                tail = tail + 1;
                done = (tail >= STARTUP_CLKS) && !hang_in;
            end else if (!busy) begin
                rx_sum_out = rx_sum_out * 16'h0003 + pins_in.data;
                rx_cnt_out = rx_cnt_out + 8'h01;
                left = pins_in.data[0] + pins_in.data[1];
                init_n = !crc_err_in;
            end
        end
    end
    // busy for 0..2 periods, changed at the fall so it is steady at a rise
    always @(negedge cfg_clk_in) begin
        busy = (left != 0);
        if (left != 0) left = left - 1;
    end
endmodule : spc_dev_model
`default_nettype wire

// File: bench/spc_host_tb_top.sv
/* top bench: host against the device model with random bytes, stalls,
   a crc failure, a start-up timeout and a refused start; defs compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module spc_host_tb_top;
    localparam int LEN = 12;
    localparam spc_pkg::spc_pins_type RST_PINS = '{1'b1, 1'b1, 1'b1, 3'h6, 1'b0, 8'h00};
    logic                  ref_clk = 1'b0, arst_n = 1'b0, start = 1'b0, pu = 1'b0;
    logic                  valid = 1'b0, last = 1'b0, crc = 1'b0, hang = 1'b0;
    logic [7:0]            data = 8'h00, lfsr_r = 8'h46;
    logic [15:0]           exp_sum;
    int                    fails = 0, cmp_count = 0, cycles = 0;
    logic                  ready, cfg_clk, busy, done_ok, err;
    logic [15:0]           rx_sum;
    logic [7:0]            rx_cnt;
    spc_pkg::spc_stat_type stat;
    spc_pkg::spc_pins_type pins;
    spc_host #(.PROG_LOW_CYC(50), .HALF_CYC(4), .FLUSH_CLKS(8)) u_spc_host (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n), .start_in(start), .pullup_disable_in(pu),
        .data_in(data), .data_valid_in(valid), .data_last_in(last), .data_ready_out(ready),
        .stat_in(stat), .pins_out(pins), .cfg_clk_out(cfg_clk), .busy_out(busy),
        .done_ok_out(done_ok), .error_out(err));
    spc_dev_model #(.FILE_LEN(LEN), .STARTUP_CLKS(4)) u_spc_dev_model (
        .pins_in(pins), .cfg_clk_in(cfg_clk), .crc_err_in(crc), .hang_in(hang),
        .stat_out(stat), .rx_sum_out(rx_sum), .rx_cnt_out(rx_cnt));
    function automatic logic [7:0] lfsr_next();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction : lfsr_next
    function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] b);
        return s * 16'h0003 + {8'h00, b};
    endfunction : fold
    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // one download; bytes offered before load and a start mid-load must be ignored
    // crc leads the byte stream by one, so capture stops after err_at bytes
    task automatic run(input logic pu_v, input int err_at, input logic hang_v);
        int  i;
        int  g;
        logic ok;
        ok = (err_at < 0) && !hang_v;
        pu = pu_v;
        hang = hang_v;
        exp_sum = 16'h0000;
        start = 1'b1;
        @(negedge ref_clk);
        for (i = 0; i < LEN && err !== 1'b1; i++) begin
            data = lfsr_next();
            last = (i == LEN - 1);
            crc = (i == err_at);
            valid = 1'b1;
            start = (i == 3);
            for (g = 0; ready !== 1'b1 && err !== 1'b1 && g < 3000; g++) @(negedge ref_clk);
            exp_sum = fold(exp_sum, data);
            @(negedge ref_clk);
            valid = 1'b0;
            start = 1'b0;
            // at least one idle cycle, so valid and start never flip twice in a step
            repeat (1 + int'(lfsr_r[0])) @(negedge ref_clk);
        end
        for (g = 0; done_ok !== 1'b1 && err !== 1'b1 && g < 3000; g++) @(negedge ref_clk);
        repeat (2) @(negedge ref_clk);
        crc = 1'b0;
        `CHK(done_ok, ok)
        `CHK(err, !ok)
        `CHK({pins.chip_sel_n, pins.read_write_n, cfg_clk}, 3'h6)
        `CHK(busy, 1'b0)
        `CHK(pins.pullup_disable_ctl, pu_v)
        if (err_at < 0) `CHK(rx_cnt, 8'(LEN))
        if (err_at < 0) `CHK(rx_sum, exp_sum)
        if (err_at >= 0) `CHK(rx_cnt < 8'(LEN), 1'b1)
        if (err_at >= 0) `CHK(rx_cnt, 8'(err_at))
    endtask : run
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard, far above the four downloads of a few hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        `CHK(pins, RST_PINS)
        arst_n = 1'b1;
        @(negedge ref_clk);
        `CHK(pins, RST_PINS)
        `CHK({busy, done_ok, err, cfg_clk, ready}, 5'h00)
        run(1'b1, -1, 1'b0);
        run(1'b0, 5, 1'b0);
        run(1'b0, -1, 1'b1);
        run(1'b1, -1, 1'b0);
        tally_and_finish();
    end
endmodule : spc_host_tb_top
bind spc_host spc_host_chk #(.PROG_LOW_CYC(PROG_LOW_CYC)) u_spc_host_chk (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .stat_in(stat_in), .pins_out(pins_out),
    .cfg_clk_out(cfg_clk_out), .busy_out(busy_out), .done_ok_out(done_ok_out),
    .error_out(error_out));
`default_nettype wire
